/* File: design/pcm_cycle_engine.sv */
// Pin engine: one read or write bus cycle on the memory's strobes
`timescale 1ns/100ps
module pcm_cycle_engine
    import pcm_host_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          req_valid,
    input  wire cycle_req_type req,
    output logic               req_ready,
    output logic               done,
    output logic [15:0]        rdata,
    input  wire logic [15:0]   dq_sync,
    output logic               ce_n,
    output logic               oe_n,
    output logic               we_n,
    output logic [23:0]        addr,
    output logic [15:0]        dq_out,
    output logic               dq_oe
);
    typedef enum logic [3:0] {
        CY_IDLE  = 4'b0001,
        CY_SETUP = 4'b0010,
        CY_PULSE = 4'b0100,
        CY_HOLD  = 4'b1000
    } cy_state_type;

    cy_state_type  state_q, state_d;
    logic [7:0]    cnt_q;
    cycle_req_type req_q;
    logic [15:0]   rdata_q;
    logic          done_q;

    wire cnt_zero = (cnt_q == 8'd0);
    wire take     = (state_q == CY_IDLE) && req_valid;

    always_comb
    begin
        case (state_q)
            CY_IDLE:  state_d = take ? CY_SETUP : CY_IDLE;
            CY_SETUP: state_d = cnt_zero ? CY_PULSE : CY_SETUP;
            CY_PULSE: state_d = cnt_zero ? CY_HOLD : CY_PULSE;
            CY_HOLD:  state_d = CY_IDLE;
            default:  state_d = CY_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q <= CY_IDLE;
            cnt_q   <= 8'd0;
            req_q   <= '0;
            rdata_q <= 16'h0000;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            done_q  <= (state_q == CY_HOLD);
            // Counter runs down to zero inclusive, so load one less than the cycles wanted
            if (take)
            begin
                req_q <= req;
                cnt_q <= SETUP_CYCLES - 8'd1;
            end
            else if (state_q == CY_SETUP && cnt_zero)
                cnt_q <= (req_q.write ? STROBE_CYCLES : OUT_CYCLES) - 8'd1;
            else if (!cnt_zero)
                cnt_q <= cnt_q - 8'd1;
            // Data sampled late in the pulse, after the synchroniser delay
            if (state_q == CY_PULSE && cnt_zero && !req_q.write)
                rdata_q <= dq_sync;
        end
    end

    wire in_cycle = (state_q != CY_IDLE);
    wire pulse    = (state_q == CY_PULSE);

    assign req_ready = (state_q == CY_IDLE);
    assign done      = done_q;
    assign rdata     = rdata_q;
    assign ce_n      = !in_cycle;
    // Write and output enable never overlap; data latched on we_n rise
    assign we_n      = !(pulse && req_q.write);
    assign oe_n      = !(pulse && !req_q.write);
    assign addr      = req_q.addr;
    assign dq_out    = req_q.data;
    assign dq_oe     = in_cycle && req_q.write;

    property p_no_overlap;
        @(posedge clk) disable iff (!resetn) !(!oe_n && !we_n);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("oe and we asserted together");

    property p_we_len;
        @(posedge clk) disable iff (!resetn) $fell(we_n) |-> !we_n [*6] ##1 we_n;
    endproperty
    a_we_len: assert property (p_we_len) else $error("write strobe width wrong");
endmodule

/* File: design/pcm_host.sv */
// Host controller driving the memory's command interface from AHB-Lite registers
`timescale 1ns/100ps
// Overview of operation
// - Word program: code 40 then address and data write.
// - Host issues array read after programming before expecting array data.
// - Code e8 starts buffered program with up to 32 words.
// - Confirm d0 after buffer data starts programming.
// - Code c0 then address and data programs protection registers.
// - Output enable and write strobe are never asserted together.
module pcm_host
    import pcm_host_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             rst_n,
    output logic      [23:0] addr,
    output logic      [15:0] dq_out,
    output logic             dq_oe,
    input  wire logic [15:0] dq_in
);
    typedef enum logic [7:0] {
        H_IDLE   = 8'b0000_0001,
        H_CMD    = 8'b0000_0010,
        H_DATA   = 8'b0000_0100,
        H_COUNT  = 8'b0000_1000,
        H_STREAM = 8'b0001_0000,
        H_CONF   = 8'b0010_0000,
        H_READ   = 8'b0100_0000,
        H_RESET  = 8'b1000_0000
    } host_state_type;

    // Only assigned codes pass; anything else is refused with an error flag
    function automatic logic code_known(input logic [7:0] c);
        case (c)
            CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_ID, CMD_READ_QUERY, CMD_CLEAR_STATUS,
            CMD_PROG_SETUP, CMD_PROG_ALT, CMD_BIT_ALT_PROG, CMD_BUF_PROG, CMD_BUF_BIT_ALT,
            CMD_BUF_ALL_ONES, CMD_CONFIRM, CMD_ERASE_SETUP, CMD_SUSPEND, CMD_LOCK_SETUP,
            CMD_LOCK_BLOCK, CMD_LOCK_DOWN, CMD_PROT_SETUP: code_known = 1'b1;
            default: code_known = 1'b0;
        endcase
    endfunction

    function automatic logic code_is_program(input logic [7:0] c);
        code_is_program = (c == CMD_PROG_SETUP) || (c == CMD_PROG_ALT) || (c == CMD_BIT_ALT_PROG)
                       || (c == CMD_ERASE_SETUP) || (c == CMD_PROT_SETUP);
    endfunction

    host_state_type  state_q, state_d;
    logic [31:0]     ctrl_q;
    logic [23:0]     addr_q;
    logic [15:0]     wdata_q;
    logic [15:0]     rdata_q;
    logic [15:0]     buf_q [BUF_MAX_WORDS];
    logic [5:0]      buf_cnt_q;
    logic [5:0]      idx_q;
    logic            busy_q;
    logic            bad_code_q;
    logic            array_mode_q;
    logic [7:0]      rst_cnt_q;
    logic            ap_valid_q;
    logic            ap_write_q;
    logic [7:0]      ap_addr_q;
    logic [31:0]     hrdata_q;
    logic            step_sent_q;
    logic [7:0]      low_cnt_q;

    // Engine handshake
    cycle_req_type   creq;
    logic            creq_valid;
    logic            creq_ready;
    logic            cdone;
    logic [15:0]     crdata;
    logic [15:0]     dq_sync;

    pcm_sync2 u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (dq_in),
        .sync_out (dq_sync)
    );

    pcm_cycle_engine u_engine (
        .clk       (clk),
        .resetn    (resetn),
        .req_valid (creq_valid),
        .req       (creq),
        .req_ready (creq_ready),
        .done      (cdone),
        .rdata     (crdata),
        .dq_sync   (dq_sync),
        .ce_n      (ce_n),
        .oe_n      (oe_n),
        .we_n      (we_n),
        .addr      (addr),
        .dq_out    (dq_out),
        .dq_oe     (dq_oe)
    );

    // AHB-Lite slave, zero wait states
    wire        ap_take  = hsel && hready && htrans[1];
    wire        wr_now   = ap_valid_q && ap_write_q;
    wire        rd_sel   = ap_valid_q && !ap_write_q;
    wire [7:0]  code     = ctrl_q[CTRL_CODE_LSB +: 8];
    wire [3:0]  op       = ctrl_q[CTRL_OP_LSB +: 4];
    wire        go       = wr_now && (ap_addr_q == REG_CTRL) && hwdata[CTRL_GO_BIT] && !busy_q;
    wire        go_reset = wr_now && (ap_addr_q == REG_CTRL) && hwdata[CTRL_RST_BIT] && !busy_q;
    wire        go_code  = code_known(hwdata[CTRL_CODE_LSB +: 8]);
    wire        buf_wr   = wr_now && (ap_addr_q == REG_BUF) && !busy_q && (buf_cnt_q < BUF_MAX_COUNT);
    wire        last_buf = (idx_q == buf_cnt_q - 6'd1);

    always_comb
    begin
        case (ap_addr_q)
            REG_CTRL:   hrdata_q = ctrl_q;
            REG_ADDR:   hrdata_q = {8'h00, addr_q};
            REG_WDATA:  hrdata_q = {16'h0000, wdata_q};
            REG_RDATA:  hrdata_q = {16'h0000, rdata_q};
            REG_STATUS: hrdata_q = {16'h0000, 2'b00, buf_cnt_q, 5'd0, array_mode_q, bad_code_q, busy_q};
            default:    hrdata_q = 32'h0000_0000;
        endcase
    end

    assign hrdata    = rd_sel ? hrdata_q : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Sequence control
    always_comb
    begin
        case (state_q)
            H_IDLE:   state_d = go_reset ? H_RESET : (go && go_code) ? H_CMD : H_IDLE;
            H_CMD:    state_d = !cdone ? H_CMD
                              : (op == OP_WRITE2) ? H_DATA
                              : (op == OP_BUFFER) ? H_COUNT
                              : (op == OP_STATUS) ? H_READ : H_IDLE;
            H_DATA:   state_d = cdone ? H_IDLE : H_DATA;
            H_COUNT:  state_d = cdone ? H_STREAM : H_COUNT;
            H_STREAM: state_d = (cdone && last_buf) ? H_CONF : H_STREAM;
            H_CONF:   state_d = cdone ? H_IDLE : H_CONF;
            H_READ:   state_d = cdone ? H_IDLE : H_READ;
            H_RESET:  state_d = (rst_cnt_q == 8'd0) ? H_IDLE : H_RESET;
            default:  state_d = H_IDLE;
        endcase
    end

    // Request to the pin engine for the current step
    wire issued_q_n = creq_ready && !cdone;
    always_comb
    begin
        creq       = '0;
        creq_valid = 1'b0;
        case (state_q)
            H_CMD:
            begin
                // Command codes go out on the low byte
                creq       = '{write: (op != OP_READ), addr: addr_q, data: {8'h00, code}};
                creq_valid = issued_q_n && !step_sent_q;
            end
            H_DATA:
            begin
                // Second write carries target address and data
                creq       = '{write: 1'b1, addr: addr_q, data: wdata_q};
                creq_valid = issued_q_n && !step_sent_q;
            end
            H_COUNT:
            begin
                // Count is written as words minus one
                creq       = '{write: 1'b1, addr: addr_q, data: {10'd0, buf_cnt_q - 6'd1}};
                creq_valid = issued_q_n && !step_sent_q;
            end
            H_STREAM:
            begin
                creq       = '{write: 1'b1, addr: addr_q + 24'(idx_q), data: buf_q[idx_q[4:0]]};
                creq_valid = issued_q_n && !step_sent_q;
            end
            H_CONF:
            begin
                creq       = '{write: 1'b1, addr: addr_q, data: {8'h00, CMD_CONFIRM}};
                creq_valid = issued_q_n && !step_sent_q;
            end
            H_READ:
            begin
                // Each read is a fresh select toggle, so status is refreshed
                creq       = '{write: 1'b0, addr: addr_q, data: 16'h0000};
                creq_valid = issued_q_n && !step_sent_q;
            end
            default:
            begin
                creq       = '0;
                creq_valid = 1'b0;
            end
        endcase
    end


    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q      <= H_RESET;
            ctrl_q       <= CTRL_RESET_VALUE;
            addr_q       <= 24'h000000;
            wdata_q      <= 16'h0000;
            rdata_q      <= 16'h0000;
            buf_cnt_q    <= 6'd0;
            idx_q        <= 6'd0;
            busy_q       <= 1'b1;
            bad_code_q   <= 1'b0;
            array_mode_q <= 1'b0;
            rst_cnt_q    <= RESET_CYCLES;
            ap_valid_q   <= 1'b0;
            ap_write_q   <= 1'b0;
            ap_addr_q    <= 8'h00;
            step_sent_q  <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            ap_valid_q <= ap_take;
            ap_write_q <= hwrite;
            ap_addr_q  <= haddr[7:0];
            busy_q     <= (state_d != H_IDLE);
            step_sent_q <= (state_d == state_q) && !(state_q == H_STREAM && cdone) && (step_sent_q || creq_valid);
            if (state_q == H_STREAM && cdone)
                step_sent_q <= 1'b0;
            if (wr_now && ap_addr_q == REG_CTRL && !busy_q)
                ctrl_q <= hwdata;
            if (wr_now && ap_addr_q == REG_ADDR && !busy_q)
                addr_q <= hwdata[23:0];
            if (wr_now && ap_addr_q == REG_WDATA && !busy_q)
                wdata_q <= hwdata[15:0];
            if (buf_wr)
            begin
                buf_q[buf_cnt_q[4:0]] <= hwdata[15:0];
                buf_cnt_q             <= buf_cnt_q + 6'd1;
            end
            // Unassigned codes are never sent to the memory
            if (go)
                bad_code_q <= !go_code;
            if (go_reset)
                rst_cnt_q <= RESET_CYCLES;
            else if (state_q == H_RESET && rst_cnt_q != 8'd0)
                rst_cnt_q <= rst_cnt_q - 8'd1;
            if (state_q == H_STREAM && cdone)
                idx_q <= idx_q + 6'd1;
            if (state_q == H_CONF && cdone)
            begin
                idx_q     <= 6'd0;
                buf_cnt_q <= 6'd0;
            end
            if ((state_q == H_READ || (state_q == H_CMD && op == OP_READ)) && cdone)
                rdata_q <= crdata;
            // Track array read mode: code ff sets it, program, status and buffer codes clear it
            if (state_q == H_CMD && cdone && op != OP_READ)
            begin
                if (code == CMD_READ_ARRAY)
                    array_mode_q <= 1'b1;
                else if (code_is_program(code) || code == CMD_READ_STATUS || code == CMD_BUF_PROG
                         || code == CMD_BUF_BIT_ALT || code == CMD_BUF_ALL_ONES)
                    array_mode_q <= 1'b0;
            end
            // Pin reset returns the memory to array reads
            if (state_q == H_RESET && rst_cnt_q == 8'd0)
                array_mode_q <= 1'b1;
        end
    end

    assign rst_n = (state_q != H_RESET);

    // Low time of the reset pin is counted, too long for a plain repetition
    always_ff @(posedge clk)
    begin
        if (!resetn || rst_n)
            low_cnt_q <= 8'd0;
        else if (low_cnt_q != 8'hff)
            low_cnt_q <= low_cnt_q + 8'd1;
    end

    property p_reset_len;
        @(posedge clk) disable iff (!resetn) $rose(rst_n) |-> low_cnt_q > RESET_CYCLES;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset pin release glitch");

    property p_array_after_reset;
        @(posedge clk) disable iff (!resetn) $rose(rst_n) |-> ##1 array_mode_q;
    endproperty
    a_array_after_reset: assert property (p_array_after_reset) else $error("array mode not set after reset");

    sequence s_cmd_done;
        (state_q == H_CMD) && cdone && (op == OP_WRITE2);
    endsequence
    property p_second_write;
        @(posedge clk) disable iff (!resetn) s_cmd_done |-> ##[1:40] (!we_n && dq_out == wdata_q);
    endproperty
    a_second_write: assert property (p_second_write) else $error("second write missing");

    property p_confirm_code;
        @(posedge clk) disable iff (!resetn) (!we_n && state_q == H_CONF) |-> dq_out[7:0] == CMD_CONFIRM;
    endproperty
    a_confirm_code: assert property (p_confirm_code) else $error("confirm code wrong");

    property p_no_bad_code;
        @(posedge clk) disable iff (!resetn) (!we_n && state_q == H_CMD) |-> code_known(dq_out[7:0]);
    endproperty
    a_no_bad_code: assert property (p_no_bad_code) else $error("unassigned code sent");

    property p_prog_leaves_array;
        @(posedge clk) disable iff (!resetn)
            (state_q == H_CMD && cdone && op != OP_READ && code == CMD_PROG_SETUP) |=> !array_mode_q;
    endproperty
    a_prog_leaves_array: assert property (p_prog_leaves_array) else $error("array mode kept after program");

    property p_buf_limit;
        @(posedge clk) disable iff (!resetn) buf_cnt_q <= BUF_MAX_COUNT;
    endproperty
    a_buf_limit: assert property (p_buf_limit) else $error("buffer overfilled");

    property p_oe_we;
        @(posedge clk) disable iff (!resetn) !(!oe_n && !we_n) && !(dq_oe && !oe_n);
    endproperty
    a_oe_we: assert property (p_oe_we) else $error("drive conflict");
endmodule

/* File: design/pcm_host_pkg.sv */
// Package with command codes, register map and bus carriers for the memory command host
package pcm_host_pkg;

    // Command codes written to the memory
    localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
    localparam logic [7:0] CMD_READ_ID       = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY    = 8'h98;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_PROG_SETUP    = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT      = 8'h10;
    localparam logic [7:0] CMD_BIT_ALT_PROG  = 8'h42;
    localparam logic [7:0] CMD_BUF_PROG      = 8'he8;
    localparam logic [7:0] CMD_BUF_BIT_ALT   = 8'hea;
    localparam logic [7:0] CMD_BUF_ALL_ONES  = 8'hde;
    localparam logic [7:0] CMD_CONFIRM       = 8'hd0;
    localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
    localparam logic [7:0] CMD_SUSPEND       = 8'hb0;
    localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
    localparam logic [7:0] CMD_LOCK_BLOCK    = 8'h01;
    localparam logic [7:0] CMD_LOCK_DOWN     = 8'h2f;
    localparam logic [7:0] CMD_PROT_SETUP    = 8'hc0;

    // Status bit positions in the memory's status byte
    localparam int LOCK_ERROR_BIT      = 1;
    localparam int PROG_VOLT_ERROR_BIT = 3;
    localparam int PROG_ERROR_BIT      = 4;
    localparam int ERASE_ERROR_BIT     = 5;
    localparam int PROG_SUSPEND_BIT    = 2;
    localparam int ERASE_SUSPEND_BIT   = 6;
    localparam int SEQ_READY_BIT       = 7;
    localparam logic [7:0] STATUS_RESET_VALUE = 8'h80;

    // Buffered programming limit
    localparam int          BUF_MAX_WORDS = 32;
    localparam logic [5:0]  BUF_MAX_COUNT = 6'd32;

    // Host registers, byte offsets on AHB-Lite
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_BUF    = 8'h14;
    localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;

    // Control register fields
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_CODE_LSB = 8;
    localparam int CTRL_GO_BIT   = 31;
    localparam int CTRL_RST_BIT  = 30;

    // Pin timing, cycles at 100 MHz
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         STROBE_NS       = 60;
    localparam int         SETUP_NS        = 20;
    localparam int         OUT_NS          = 120;
    localparam int         RESET_NS        = 100;
    localparam logic [7:0] STROBE_CYCLES   = 8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SETUP_CYCLES    = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] OUT_CYCLES      = 8'((OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESET_CYCLES    = 8'((RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Operations that software orders
    typedef enum logic [3:0] {
        OP_WRITE1  = 4'h0,   // one command write
        OP_WRITE2  = 4'h1,   // setup code then address/data write
        OP_READ    = 4'h2,   // one read cycle
        OP_BUFFER  = 4'h3,   // buffered program sequence
        OP_STATUS  = 4'h4    // status poll: code then read
    } op_type;

    // Pin side carrier toward the memory
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        rst_n;
        logic [23:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe;
    } pin_out_type;

    // One cycle request to the pin engine
    typedef struct packed {
        logic        write;
        logic [23:0] addr;
        logic [15:0] data;
    } cycle_req_type;

endpackage

/* File: design/pcm_sync2.sv */
// Two-flop synchroniser for the memory data lines
`timescale 1ns/100ps
module pcm_sync2
    import pcm_host_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [15:0] async_in,
    output logic      [15:0] sync_out
);
    logic [15:0] meta_q;
    logic [15:0] sync_q;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_q <= 16'h0000;
            sync_q <= 16'h0000;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

/* File: verif/pcm_mem_model.sv */
// Behavioural memory device on the host's strobes
`timescale 1ns/100ps
module pcm_mem_model #(
    parameter logic [15:0] MFR_ID = 16'h00a7 // Arbitrary code
)(
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    input wire logic [23:0] addr,
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in
);
    logic [15:0] mem [256];
    logic [15:0] val;
    logic [15:0] last;
    logic [7:0] sr;
    logic [7:0] pend;
    logic [7:0] cd;
    logic [1:0] md;
    logic [5:0] left;
    logic conf;
    wire wr = ~ce_n & ~we_n & oe_n;
    wire rd = ~ce_n & ~oe_n & rst_n;
    // Status is combinational, so every select toggle presents a fresh value
    assign val = md == 2'h0 ? mem[addr[7:0]] : md == 2'h1 ? {8'h00, sr} :
                 md == 2'h2 ? (addr[7:0] == 8'h00 ? MFR_ID : 16'h0) : 16'h0051;
    // A released bus shows the inverse, so a stale word never looks valid
    assign dq_in = rd ? val : ~last;
    initial
    begin
        foreach (mem[i]) mem[i] = 16'hffff;
        last = 16'h0000;
    end
    always @(posedge oe_n) last = val;
    // Fall of wr is whichever of strobe or select rises first
    always @(negedge wr or negedge rst_n)
    begin
        cd = dq_out[7:0];
        if (!rst_n)
        begin
            sr = 8'h80;
            md = 2'h0;
            pend = 8'h00;
            left = 6'd0;
            conf = 1'b0;
        end
        else if (left != 6'd0)
        begin
            mem[addr[7:0]] = dq_out;
            left = left - 6'd1;
            conf = left == 6'd0;
        end
        else if (conf)
        begin
            if (cd != 8'hd0)
                sr[5:4] = 2'b11;
            md = 2'h1;
            conf = 1'b0;
        end
        else if (pend == 8'he8 || pend == 8'hea || pend == 8'hde)
        begin
            left = dq_out[5:0] + 6'd1;
            pend = 8'h00;
        end
        else if (pend == 8'h40 || pend == 8'h10 || pend == 8'h42)
        begin
            mem[addr[7:0]] = dq_out;
            md = 2'h1;
            pend = 8'h00;
        end
        else if (pend == 8'h20 || pend == 8'h60)
        begin
            if (pend == 8'h20 && cd == 8'hd0)
                for (int i = 0; i < 16; i++) mem[{addr[7:4], 4'(i)}] = 16'hffff;
            else if (pend == 8'h20 || !(cd == 8'h01 || cd == 8'hd0 || cd == 8'h2f))
                sr[5:4] = 2'b11;
            md = pend == 8'h20 ? 2'h1 : md;
            pend = 8'h00;
        end
        else if (cd == 8'hff) md = 2'h0;
        else if (cd == 8'h70) md = 2'h1;
        else if (cd == 8'h90) md = 2'h2;
        else if (cd == 8'h98) md = 2'h3;
        else if (cd == 8'h50) sr = sr & 8'hc5;
        else if (cd == 8'hb0) sr = sr | 8'h84;
        else if (cd == 8'hd0) sr = sr & 8'hbb;
        else pend = cd;
    end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the memory host controller
`timescale 1ns/100ps
module testbench;
    import pcm_host_pkg::*;
    localparam logic [15:0] ID = 16'h00a7; // Arbitrary code
    typedef struct packed {logic [7:0] c; logic [3:0] o; logic [7:0] a; logic [15:0] d, e;} row_type;
    logic clk, resetn, hsel, hwrite, hreadyout, hresp, ce_n, oe_n, we_n, rst_n, dq_oe;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [23:0] addr;
    logic [15:0] dq_out, dq_in;
    int err_count, num_checks;
    row_type rows [16] = '{'{8'h40,4'h1,8'h03,16'ha5a5,16'h0}, '{8'h70,4'h4,8'h03,16'h0,16'h80},
        '{8'hff,4'h4,8'h03,16'h0,16'ha5a5}, '{8'h10,4'h1,8'h04,16'h1200,16'h0},
        '{8'h42,4'h1,8'h04,16'h00ff,16'h0}, '{8'hff,4'h4,8'h04,16'h0,16'h00ff},
        '{8'h90,4'h4,8'h00,16'h0,ID}, '{8'h98,4'h4,8'h00,16'h0,16'h51},
        '{8'h20,4'h1,8'h03,16'h11,16'h0}, '{8'h70,4'h4,8'h03,16'h0,16'hb0},
        '{8'h50,4'h0,8'h00,16'h0,16'h0}, '{8'h70,4'h4,8'h00,16'h0,16'h80},
        '{8'h60,4'h1,8'h03,16'h99,16'h0}, '{8'h70,4'h4,8'h00,16'h0,16'hb0},
        '{8'h20,4'h1,8'h05,16'hd0,16'h0}, '{8'hff,4'h4,8'h03,16'h0,16'hffff}};
    pcm_host u_pcm_host (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ce_n, .oe_n, .we_n, .rst_n, .addr, .dq_out, .dq_oe, .dq_in);
    pcm_mem_model #(.MFR_ID(ID)) u_pcm_mem_model (.ce_n, .oe_n, .we_n, .rst_n, .addr, .dq_out, .dq_in);
    task check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
        end
    endtask
    task wrap_up;
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task step(inout int n);
        @(posedge clk);
        n++;
        if (n > 900)
        begin
            err_count++;
            wrap_up;
        end
    endtask
    task rdy;
        int n;
        n = 0;
        do step(n); while (hreadyout !== 1'b1);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        rdy;
        htrans <= 2'b00;
        hwdata <= d;
        rdy;
        r = hrdata;
    endtask
    task idle;
        int n;
        n = 0;
        do bus(1'b0, REG_STATUS, 32'h0); while (r[0] !== 1'b0 && n++ < 900);
        if (n > 899) step(n);
    endtask
    task op(input logic [7:0] c, input logic [3:0] o, input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, REG_ADDR, {24'h0, a});
        bus(1'b1, REG_WDATA, {16'h0, d});
        bus(1'b1, REG_CTRL, {1'b1, 15'h0, c, 4'h0, o});
        idle;
        if (o > 4'h1) bus(1'b0, REG_RDATA, 32'h0);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {resetn, hwrite, haddr, htrans, hwdata} = 68'h0;
        err_count = 0;
        num_checks = 0;
        hsel = 1'b1;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        idle;
        foreach (rows[i])
        begin
            op(rows[i].c, rows[i].o, rows[i].a, rows[i].d);
            if (rows[i].o == 4'h4) check(r, {16'h0, rows[i].e});
        end
        // Leave status mode and error bits behind, then reset in mid-run
        op(8'h40, 4'h1, 8'h03, 16'h5a5a);
        op(8'h20, 4'h1, 8'h03, 16'h11);
        resetn <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        idle;
        // Unassigned code is refused and flagged; the memory is back in array mode
        bus(1'b1, REG_CTRL, 32'h8000_3300);
        bus(1'b0, REG_STATUS, 32'h0);
        check(r, 32'h6);
        op(8'hff, 4'h2, 8'h03, 16'h0);
        check(r, 32'h5a5a);
        op(8'h70, 4'h4, 8'h03, 16'h0);
        check(r, 32'h80);
        // Suspension outlives mode changes until resume or the reset pin
        op(8'hb0, 4'h0, 8'h00, 16'h0);
        op(8'hff, 4'h4, 8'h03, 16'h0);
        check(r, 32'h5a5a);
        op(8'h70, 4'h4, 8'h03, 16'h0);
        check(r, 32'h84);
        op(8'hd0, 4'h0, 8'h00, 16'h0);
        op(8'h70, 4'h4, 8'h03, 16'h0);
        check(r, 32'h80);
        op(8'hb0, 4'h0, 8'h00, 16'h0);
        bus(1'b1, REG_CTRL, 32'h4000_0000);
        idle;
        op(8'h70, 4'h4, 8'h03, 16'h0);
        check(r, 32'h80);
        // Buffered writes: two bit-alterable words, then one on an all-ones page
        bus(1'b1, REG_BUF, 32'h1234);
        bus(1'b1, REG_BUF, 32'h5678);
        bus(1'b0, REG_STATUS, 32'h0);
        check(r, 32'h200);
        op(8'hea, 4'h3, 8'h20, 16'h0);
        op(8'hff, 4'h4, 8'h21, 16'h0);
        check(r, 32'h5678);
        bus(1'b1, REG_BUF, 32'h0f0f);
        op(8'hde, 4'h3, 8'h30, 16'h0);
        op(8'hff, 4'h4, 8'h30, 16'h0);
        check(r, 32'h0f0f);
        bus(1'b0, 8'h40, 32'h0);
        check(r, 32'h0);
        check({30'h0, hresp, hreadyout}, 32'h1);
        wrap_up;
    end
endmodule
